//--- sim/icr_ctrl_one_properties.sv
`timescale 1ns/1ps
// Watches control register one at its ports
module icr_ctrl_one_properties #(
  parameter ADDR_W = 12
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Read channel
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_rvalid,
  input wire [31:0] s_axi_rdata,
  // Engine side
  input wire engIrqReq,
  input wire rxBitsDone,
  input wire rxByteDone,
  input wire txByteDone,
  input wire addrMatch,
  input wire fastAck,
  input wire lowPower,
  // Block outputs
  input wire engineEnable_ff,
  input wire masterMode_ff,
  input wire startReq_ff,
  input wire stopReq_ff,
  input wire repStartReq_ff,
  input wire arbLost_ff,
  input wire sclHold_ff,
  input wire irqOut_ff,
  input wire wakeupReq_ff,
  input wire dmaReq_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Remembers whether the pending read targets the control word
  reg rdCtrl_ff;
  always @(posedge clk) begin
    if (sys_rst)
      rdCtrl_ff <= 1'b0;
    else if (s_axi_arvalid && s_axi_arready)
      rdCtrl_ff <= (s_axi_araddr == {{(ADDR_W-4){1'b0}}, 4'h8});
  end
  AST_MST_EN: assert property (masterMode_ff |-> engineEnable_ff)
    else $error("master mode with engine off");
  AST_IRQ_SRC: assert property (irqOut_ff |-> $past(engIrqReq))
    else $error("irq without engine request");
  AST_START: assert property (startReq_ff |-> !stopReq_ff ##1 masterMode_ff)
    else $error("start outside master mode");
  AST_STOP: assert property (stopReq_ff |=> !masterMode_ff)
    else $error("stop while still master");
  AST_REPEAT_START_REQUEST: assert property (repStartReq_ff |-> masterMode_ff && !arbLost_ff)
    else $error("repeat start while not master");
  AST_REPEAT_START_REQUEST_RD: assert property (s_axi_rvalid && rdCtrl_ff |-> !s_axi_rdata[2])
    else $error("repeat start bit read as one");
  AST_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  AST_WAKE: assert property (wakeupReq_ff |-> $past(addrMatch) && $past(lowPower))
    else $error("wakeup without match in low power");
  AST_DMA: assert property (dmaReq_ff |-> $past(rxByteDone) || $past(txByteDone)
    || $past(addrMatch))
    else $error("dma request without cause");
  AST_DMA_FA: assert property (dmaReq_ff && $past(fastAck) |-> $past(txByteDone))
    else $error("dma request in fast ack without tx byte");
  AST_SCL: assert property ($rose(sclHold_ff) |-> $past(rxBitsDone) && $past(fastAck))
    else $error("clock stretch without received bits");
  // Main scenarios reached
  cover property (startReq_ff);
  cover property (dmaReq_ff);
  cover property ($rose(sclHold_ff));
endmodule

bind icr_ctrl_one icr_ctrl_one_properties #(.ADDR_W(ADDR_W)) prop_u (.clk(clk),
  .sys_rst(sys_rst), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
  .engIrqReq(engIrqReq), .rxBitsDone(rxBitsDone), .rxByteDone(rxByteDone),
  .txByteDone(txByteDone), .addrMatch(addrMatch), .fastAck(fastAck), .lowPower(lowPower),
  .engineEnable_ff(engineEnable_ff),
  .masterMode_ff(masterMode_ff), .startReq_ff(startReq_ff), .stopReq_ff(stopReq_ff),
  .repStartReq_ff(repStartReq_ff), .arbLost_ff(arbLost_ff), .sclHold_ff(sclHold_ff),
  .irqOut_ff(irqOut_ff), .wakeupReq_ff(wakeupReq_ff), .dmaReq_ff(dmaReq_ff));

//--- sim/icr_eng_model.sv
`timescale 1ns/1ps
// Stand-in for the engine and the bus parties beyond it
module icr_eng_model (
  // Clock
  input wire logic clk,
  // Event pulses and levels
  output logic [7:0] evBus,
  output logic fastAck,
  output logic repStartOk,
  output logic lowPower
);
  // Quiet bus at time zero
  initial begin
    evBus = 8'h00;
    fastAck = 1'b0;
    repStartOk = 1'b0;
    lowPower = 1'b0;
  end
  // Levels change just after an edge
  task lv(input logic f, input logic r, input logic l);
    fastAck <= f;
    repStartOk <= r;
    lowPower <= l;
  endtask
  // One-cycle event after an optional stall; remote master only writes here
  task ev(input logic [7:0] m, input integer gap);
    repeat (gap) @(posedge clk);
    evBus <= m;
    @(posedge clk);
    evBus <= 8'h00;
    repeat (3) @(posedge clk);
  endtask
endmodule

//--- sim/tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for control register one
module tb_top;
  localparam [11:0] CTL = 12'h008;
  localparam [11:0] STA = 12'h00c;
  localparam [1:0] OK = 2'h0;
  reg clk = 1'b0;
  reg sys_rst = 1'b1;
  // Bus master side
  reg awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  reg [11:0] awa = 12'h000, ara = 12'h000;
  reg [31:0] wd = 32'h0;
  wire awr, wrd, bv, arr, rv, mm, tm, al, ar, sh, ee;
  wire [1:0] br, rr;
  wire [31:0] rd;
  wire [6:0] pul;
  wire [7:0] ev;
  wire fa, ro, lp;
  integer cnt[0:6] = '{default: 0};
  integer base[0:6];
  integer nErrors = 0, testsRun = 0;
  always #10 clk = ~clk;
  icr_eng_model eng_u (.clk(clk), .evBus(ev), .fastAck(fa), .repStartOk(ro), .lowPower(lp));
  icr_ctrl_one #(.ADDR_W(12)) dut_u (.clk(clk), .sys_rst(sys_rst),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_bvalid(bv),
    .s_axi_bready(bre), .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rre), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .engIrqReq(ev[7]), .rxBitsDone(ev[6]), .ackSlotDone(ev[5]),
    .rxByteDone(ev[4]), .txByteDone(ev[3]), .addrMatch(ev[2]), .primaryMatch(ev[1]),
    .generalCall(ev[0]), .fastAck(fa), .repStartOk(ro), .lowPower(lp),
    .engineEnable_ff(ee), .masterMode_ff(mm), .txMode_ff(tm), .startReq_ff(pul[0]),
    .stopReq_ff(pul[1]), .repStartReq_ff(pul[2]), .arbLost_ff(pul[3]), .ackLevel_ff(al),
    .ackReady_ff(ar), .sclHold_ff(sh), .irqOut_ff(pul[4]), .wakeupReq_ff(pul[6]),
    .dmaReq_ff(pul[5]));
  // Pulse counters; tests compare against a snapshot
  always @(posedge clk) begin
    for (int k = 0; k < 7; k++) if (!sys_rst && pul[k] === 1'b1) cnt[k] <= cnt[k] + 1;
  end
  task chk(input string n, input [31:0] s, input [31:0] e);
    testsRun++;
    if (s !== e) begin
      nErrors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task sv;
    for (int k = 0; k < 7; k++) base[k] = cnt[k];
  endtask
  task ck(input integer k, input integer e);
    chk($sformatf("pulse%0d", k), cnt[k] - base[k], e);
  endtask
  // Write; address and data offered together, each released once taken
  task wr(input [11:0] a, input [7:0] d, input [1:0] e);
    reg ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge clk);
      if (awr) ta = 1'b1;
      if (wrd) tw = 1'b1;
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end
    while (bv !== 1'b1) @(posedge clk);
    bre <= 1'b0;
    chk("bresp", br, e);
    repeat (3) @(posedge clk);
  endtask
  task rdc(input [11:0] a, input [7:0] e, input [1:0] er);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    @(posedge clk);
    while (arr !== 1'b1) @(posedge clk);
    arv <= 1'b0;
    while (rv !== 1'b1) @(posedge clk);
    rre <= 1'b0;
    chk("rdata", rd, {24'h0, e});
    chk("rresp", rr, er);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", testsRun, nErrors);
    if (nErrors == 0 && testsRun > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Hang guard, far beyond the expected run
  initial begin
    #400000;
    nErrors++;
    summarize;
  end
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rdc(CTL, 8'h00, OK);
    wr(CTL, 8'hff, OK);
    rdc(CTL, 8'hfb, OK);
    wr(CTL, 8'h00, OK);
    rdc(12'h010, 8'h00, 2'h3);
    wr(12'h010, 8'h55, 2'h3);
    $display("test registers done");
    eng_u.lv(0, 1, 0);
    wr(CTL, 8'h80, OK);
    sv;
    wr(CTL, 8'hb0, OK);
    ck(0, 1);
    chk("master", {mm, tm}, 2'b11);
    sv;
    wr(CTL, 8'hb4, OK);
    ck(2, 1);
    eng_u.lv(0, 0, 0);
    sv;
    wr(CTL, 8'hb4, OK);
    ck(3, 1);
    rdc(STA, 8'h10, OK);
    wr(STA, 8'h10, OK);
    sv;
    wr(CTL, 8'h80, OK);
    ck(1, 1);
    chk("slave", {mm, tm}, 2'b00);
    $display("test master done");
    sv;
    eng_u.ev(8'h80, 0);
    ck(4, 0);
    wr(CTL, 8'hc0, OK);
    chk("enable", ee, 1'b1);
    sv;
    eng_u.ev(8'h80, 4);
    ck(4, 1);
    wr(CTL, 8'h40, OK);
    chk("enable", ee, 1'b0);
    sv;
    eng_u.ev(8'h80, 0);
    ck(4, 0);
    wr(CTL, 8'h80, OK);
    sv;
    eng_u.ev(8'h08, 0);
    ck(5, 0);
    wr(CTL, 8'h81, OK);
    sv;
    eng_u.ev(8'h10, 0);
    eng_u.ev(8'h08, 0);
    eng_u.ev(8'h06, 0);
    ck(5, 3);
    eng_u.lv(1, 0, 0);
    sv;
    eng_u.ev(8'h10, 0);
    eng_u.ev(8'h08, 2);
    ck(5, 1);
    $display("test requests done");
    eng_u.lv(0, 0, 1);
    wr(CTL, 8'h02, OK);
    sv;
    eng_u.ev(8'h06, 0);
    ck(6, 1);
    wr(CTL, 8'h00, OK);
    sv;
    eng_u.ev(8'h06, 0);
    ck(6, 0);
    eng_u.lv(0, 0, 0);
    wr(CTL, 8'h80, OK);
    eng_u.ev(8'h06, 0);
    rdc(STA, 8'hc0, OK);
    wr(CTL, 8'h80, OK);
    rdc(STA, 8'h80, OK);
    wr(CTL, 8'h88, OK);
    wr(STA, 8'h00, OK);
    eng_u.ev(8'h40, 0);
    chk("ack", al, 1'b1);
    eng_u.lv(1, 0, 0);
    eng_u.ev(8'h40, 0);
    chk("hold", sh, 1'b1);
    wr(CTL, 8'h80, OK);
    chk("ackslot", {sh, ar, al}, 3'b010);
    eng_u.ev(8'h20, 0);
    chk("slotdone", ar, 1'b0);
    $display("test wakeup and ack done");
    summarize;
  end
endmodule

//--- src/icr_ack_ctrl.v
`timescale 1ns/1ps
`include "icr_defs.vh"

// Acknowledge slot control for received bytes
module icr_ack_ctrl (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Engine side
  input wire rxBitsDone,
  input wire ackSlotDone,
  input wire fastAck,
  // Register side
  input wire ackWrite,
  input wire ackValue,
  // Results
  output reg ackLevel_ff,
  output reg ackReady_ff,
  output reg sclHold_ff
);

  // Stretch in progress, waiting for software
  reg waiting_ff;

  // With fast ack the byte just received waits for software; without it,
  // the value already in the register (written for this byte) is used.
  always @(posedge clk) begin
    if (sys_rst) begin
      ackLevel_ff <= 1'b0;
      ackReady_ff <= 1'b0;
      sclHold_ff <= 1'b0;
      waiting_ff <= 1'b0;
    end else begin
      if (rxBitsDone && fastAck) begin
        // Hold SCL low until ack_control is written
        waiting_ff <= 1'b1;
        sclHold_ff <= 1'b1;
        ackReady_ff <= 1'b0;
      end else if (rxBitsDone) begin
        // Value written earlier applies to this next byte
        ackLevel_ff <= ackValue;
        ackReady_ff <= 1'b1;
      end else if (waiting_ff && ackWrite) begin
        // Software answered: release clock, drive its value
        ackLevel_ff <= ackValue;
        ackReady_ff <= 1'b1;
        waiting_ff <= 1'b0;
        sclHold_ff <= 1'b0;
      end else if (ackSlotDone) begin
        // Slot over, drop the level request
        ackReady_ff <= 1'b0;
      end
    end
  end

endmodule

//--- src/icr_ctrl_one.v
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`include "icr_defs.vh"

// Control register one with its side effects on the I2C engine
module icr_ctrl_one #(
  parameter ADDR_W = 12
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // AXI4-Lite write address
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  // AXI4-Lite write data
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  output reg [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  // AXI4-Lite read data
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  // Engine events, one-cycle pulses
  input wire engIrqReq,
  input wire rxBitsDone,
  input wire ackSlotDone,
  input wire rxByteDone,
  input wire txByteDone,
  input wire addrMatch,
  input wire primaryMatch,
  input wire generalCall,
  // Engine levels
  input wire fastAck,
  input wire repStartOk,
  input wire lowPower,
  // Engine controls
  output reg engineEnable_ff,
  output reg masterMode_ff,
  output reg txMode_ff,
  output reg startReq_ff,
  output reg stopReq_ff,
  output reg repStartReq_ff,
  output reg arbLost_ff,
  // Acknowledge slot
  output wire ackLevel_ff,
  output wire ackReady_ff,
  output wire sclHold_ff,
  // Requests to the system
  output reg irqOut_ff,
  output reg wakeupReq_ff,
  output reg dmaReq_ff
);

  // Control register storage, repeat start bit never stored
  reg [7:0] ctrl_ff;
  // Status flags kept here
  reg tcfFlag_ff;
  reg aasFlag_ff;
  reg arbFlag_ff;
  // Write channel holding registers
  reg awHeld_ff;
  reg [ADDR_W-1:0] awAddr_ff;
  reg wHeld_ff;
  reg [31:0] wData_ff;
  reg [3:0] wStrb_ff;

  // Decoded write and read targets
  wire doWrite;
  wire wrCtrlHit;
  wire wrStatHit;
  wire ctrlWrite;
  wire statWrite;
  wire rdCtrlHit;
  wire rdStatHit;
  wire [7:0] wrByte;
  wire rstaWrite;
  wire [7:0] nxt_ctrl;
  wire dmaCond;
  wire ackBit;
  reg [31:0] nxt_rdata;

  // A write goes ahead once address and data are both in hand
  assign doWrite = awHeld_ff & wHeld_ff & ~s_axi_bvalid;
  assign wrCtrlHit = (awAddr_ff[ADDR_W-1:2] == `ICR_CTRL_IDX);
  assign wrStatHit = (awAddr_ff[ADDR_W-1:2] == `ICR_STAT_IDX);
  assign wrByte = wData_ff[7:0];
  // Only the low byte lane carries register bits
  assign ctrlWrite = doWrite & wrCtrlHit & wStrb_ff[0];
  assign statWrite = doWrite & wrStatHit & wStrb_ff[0];
  assign rdCtrlHit = (s_axi_araddr[ADDR_W-1:2] == `ICR_CTRL_IDX);
  assign rdStatHit = (s_axi_araddr[ADDR_W-1:2] == `ICR_STAT_IDX);

  // Repeat start is a strobe, not a stored bit
  assign rstaWrite = ctrlWrite & wrByte[`ICR_CTRL_REPEAT_START_REQUEST];
  assign nxt_ctrl = wrByte & ~(8'h01 << `ICR_CTRL_REPEAT_START_REQUEST);
  // Ack value as the register holds it; the last bus word may belong to another register
  assign ackBit = ctrlWrite ? wrByte[`ICR_CTRL_ACK] : ctrl_ff[`ICR_CTRL_ACK];

  // Write address channel
  always @(posedge clk) begin
    if (sys_rst) begin
      awHeld_ff <= 1'b0;
      awAddr_ff <= {ADDR_W{1'b0}};
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      // Take the address and close the channel
      awHeld_ff <= 1'b1;
      awAddr_ff <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (doWrite) begin
      // Consumed by the write
      awHeld_ff <= 1'b0;
    end else begin
      // Reopen once nothing is held and no response pends
      s_axi_awready <= ~awHeld_ff & ~s_axi_bvalid;
    end
  end

  // Write data channel
  always @(posedge clk) begin
    if (sys_rst) begin
      wHeld_ff <= 1'b0;
      wData_ff <= 32'h00000000;
      wStrb_ff <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      // Take the data and close the channel
      wHeld_ff <= 1'b1;
      wData_ff <= s_axi_wdata;
      wStrb_ff <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (doWrite) begin
      wHeld_ff <= 1'b0;
    end else begin
      s_axi_wready <= ~wHeld_ff & ~s_axi_bvalid;
    end
  end

  // Write response, decode error for unmapped words
  always @(posedge clk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ICR_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      if (wrCtrlHit || wrStatHit) begin
        s_axi_bresp <= `ICR_RESP_OKAY;
      end else begin
        s_axi_bresp <= `ICR_RESP_DECERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read mux; the repeat start position is never set in storage
  always @* begin
    nxt_rdata = 32'h00000000;
    if (rdCtrlHit) begin
      nxt_rdata[7:0] = ctrl_ff;
    end else if (rdStatHit) begin
      nxt_rdata[`ICR_STAT_TCF] = tcfFlag_ff;
      nxt_rdata[`ICR_STAT_AAS] = aasFlag_ff;
      nxt_rdata[`ICR_STAT_ARBL] = arbFlag_ff;
    end else begin
      nxt_rdata = 32'h00000000;
    end
  end

  // Read channel: one read at a time, data one edge after the address
  always @(posedge clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `ICR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= nxt_rdata;
      if (rdCtrlHit || rdStatHit) begin
        s_axi_rresp <= `ICR_RESP_OKAY;
      end else begin
        s_axi_rresp <= `ICR_RESP_DECERR;
      end
    end else if (s_axi_rvalid) begin
      // Hold the answer until the master takes it
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // Control register store; software owns all stored bits
  always @(posedge clk) begin
    if (sys_rst) begin
      ctrl_ff <= `ICR_CTRL_RST;
    end else if (ctrlWrite) begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Mode outputs follow the register through one flop; master mode is also gated by enable
  always @(posedge clk) begin
    if (sys_rst) begin
      engineEnable_ff <= 1'b0;
      masterMode_ff <= 1'b0;
      txMode_ff <= 1'b0;
    end else begin
      engineEnable_ff <= ctrl_ff[`ICR_CTRL_EN];
      // Master mode only exists while the engine is on
      masterMode_ff <= ctrl_ff[`ICR_CTRL_EN] & ctrl_ff[`ICR_CTRL_MST];
      // Address cycles need transmit; software keeps that right
      txMode_ff <= ctrl_ff[`ICR_CTRL_TX];
    end
  end

  // Bus condition strobes from master select edges and repeat start writes.
  // Edges are taken on the write itself so a same-value rewrite of master select does nothing.
  always @(posedge clk) begin
    if (sys_rst) begin
      startReq_ff <= 1'b0;
      stopReq_ff <= 1'b0;
      repStartReq_ff <= 1'b0;
      arbLost_ff <= 1'b0;
    end else begin
      startReq_ff <= ctrlWrite & ctrl_ff[`ICR_CTRL_EN] &
        ~ctrl_ff[`ICR_CTRL_MST] & wrByte[`ICR_CTRL_MST];
      stopReq_ff <= ctrlWrite & ctrl_ff[`ICR_CTRL_EN] &
        ctrl_ff[`ICR_CTRL_MST] & ~wrByte[`ICR_CTRL_MST];
      // Repeat start only when already master and timing allows
      repStartReq_ff <= rstaWrite & ctrl_ff[`ICR_CTRL_EN] &
        ctrl_ff[`ICR_CTRL_MST] & repStartOk;
      // Wrong moment: report as lost arbitration instead
      arbLost_ff <= rstaWrite & ctrl_ff[`ICR_CTRL_EN] &
        ctrl_ff[`ICR_CTRL_MST] & ~repStartOk;
    end
  end

  // Status flags: hardware set wins over any clear in the same cycle
  always @(posedge clk) begin
    if (sys_rst) begin
      tcfFlag_ff <= 1'b0;
      aasFlag_ff <= 1'b0;
      arbFlag_ff <= 1'b0;
    end else begin
      if (addrMatch || rxByteDone || txByteDone) begin
        tcfFlag_ff <= 1'b1;
      end else if (statWrite && wrByte[`ICR_STAT_TCF]) begin
        tcfFlag_ff <= 1'b0;
      end
      if (addrMatch) begin
        aasFlag_ff <= 1'b1;
      end else if (ctrlWrite) begin
        // Any control write, whatever the value, clears it
        aasFlag_ff <= 1'b0;
      end
      if (arbLost_ff) begin
        arbFlag_ff <= 1'b1;
      end else if (statWrite && wrByte[`ICR_STAT_ARBL]) begin
        arbFlag_ff <= 1'b0;
      end
    end
  end

  // Requests toward the system
  // DMA serves only transfers of known direction; software keeps
  // DMA off when a remote master reads from us.
  assign dmaCond = fastAck ? txByteDone :
    (rxByteDone | txByteDone | (addrMatch & (primaryMatch | generalCall)));

  always @(posedge clk) begin
    if (sys_rst) begin
      irqOut_ff <= 1'b0;
      wakeupReq_ff <= 1'b0;
      dmaReq_ff <= 1'b0;
    end else begin
      irqOut_ff <= engIrqReq & ctrl_ff[`ICR_CTRL_IE] & ctrl_ff[`ICR_CTRL_EN];
      // Wake works without bus clock, so it needs no enable flop chain
      wakeupReq_ff <= addrMatch & lowPower & ctrl_ff[`ICR_CTRL_WAKEUP_ENABLE];
      dmaReq_ff <= ctrl_ff[`ICR_CTRL_DMA] & ctrl_ff[`ICR_CTRL_EN] & dmaCond;
    end
  end

  // Acknowledge slot handling
  icr_ack_ctrl u_ack (
    .clk(clk),
    .sys_rst(sys_rst),
    .rxBitsDone(rxBitsDone),
    .ackSlotDone(ackSlotDone),
    .fastAck(fastAck),
    .ackWrite(ctrlWrite),
    .ackValue(ackBit),
    .ackLevel_ff(ackLevel_ff),
    .ackReady_ff(ackReady_ff),
    .sclHold_ff(sclHold_ff)
  );

endmodule

//--- src/icr_defs.vh
// What this block does
// - Engine runs only while module_enable set
// - Interrupts pass only while irq_enable set
// - Master select rising drives START, master mode
// - Master select falling drives STOP, slave mode
// - Direction bit: 0 receive, 1 transmit
// - Ack slot SDA from ack_control: 0 ACK
// - Fast ack picks current or next byte
// - SCL held low until ack_control written
// - Repeat start write drives repeated START
// - Repeat start bit always reads zero
// - Misplaced repeat start counts as arbitration loss
// - Wakeup on address match in low power
// - No DMA request while DMA disabled
// - No fast ack: request on rx/tx byte
// - No fast ack: request on address match with primary match or general call
// - Fast ack: request only on transmitted byte
// - Address match sets addressed and complete flags
// - Any control write clears addressed flag
`ifndef ICR_DEFS_VH
`define ICR_DEFS_VH

// Register word indexes (byte address is four times these)
`define ICR_CTRL_IDX 10'h002
`define ICR_STAT_IDX 10'h003

// Control register field positions
`define ICR_CTRL_EN 7
`define ICR_CTRL_IE 6
`define ICR_CTRL_MST 5
`define ICR_CTRL_TX 4
`define ICR_CTRL_ACK 3
`define ICR_CTRL_REPEAT_START_REQUEST 2
`define ICR_CTRL_WAKEUP_ENABLE 1
`define ICR_CTRL_DMA 0

// Status register field positions
`define ICR_STAT_TCF 7
`define ICR_STAT_AAS 6
`define ICR_STAT_ARBL 4

// Reset values
`define ICR_CTRL_RST 8'h00

// AXI responses
`define ICR_RESP_OKAY 2'h0
`define ICR_RESP_DECERR 2'h3

`endif
